//--- core/sbfr_array.sv
// two-lane storage array with per-lane write and flow-through read
// assumes one clock; read data is combinational from the array
`timescale 1ns/100ps
`include "sbfr_cfg.svh"
module sbfr_array #(
  parameter int ADDR_W = `SBFR_ADDR_W,
  parameter int LANE_W = `SBFR_LANE_W,
  parameter int DEPTH  = `SBFR_DEPTH
) (
  // clock
  input  wire logic              clk_sys_i,
  // write side
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              wr_lo_i,
  input  wire logic              wr_hi_i,
  input  wire logic [LANE_W-1:0] wdata_lo_i,
  input  wire logic [LANE_W-1:0] wdata_hi_i,
  // read side
  output logic      [LANE_W-1:0] rdata_lo_o,
  output logic      [LANE_W-1:0] rdata_hi_o
);
  logic [LANE_W-1:0] mem_lo [DEPTH];
  logic [LANE_W-1:0] mem_hi [DEPTH];

  // self-timed write, one edge, per lane
  always_ff @(posedge clk_sys_i) begin
    if (wr_lo_i) begin
      mem_lo[addr_i] <= wdata_lo_i;
    end
    if (wr_hi_i) begin
      mem_hi[addr_i] <= wdata_hi_i;
    end
  end

  // flow-through: the address is already registered upstream, so
  // adding a read register here would cost a full cycle of latency
  assign rdata_lo_o = mem_lo[addr_i];
  assign rdata_hi_o = mem_hi[addr_i];
endmodule

//--- core/sbfr_cfg.svh
// constants for the synchronous burst flow-through sram core
// assumes inclusion by bare name from core files only
`ifndef SBFR_CFG_SVH
`define SBFR_CFG_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SBFR_ADDR_W   16
`define SBFR_LANE_W   9
`define SBFR_DATA_W   18
`define SBFR_DEPTH    65536

// ----------------------------------------------------------------
// burst counter
// ----------------------------------------------------------------
`define SBFR_CNT_W    2
`define SBFR_CNT_RST  2'h0

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define SBFR_CLK_NS   8

`endif

//--- core/sbfr_core.sv
// synchronous burst flow-through sram core, 64k x 18
// assumes inputs other than rst_i and out_enable_n_i synchronous to clk_sys_i; burst order is a strap
//
// What this block does
// - store 64k words of 18 bits as two 9-bit lanes
// - register address, data and controls except enable and order
// - either start strobe loads an external address
// - 2-bit counter advances on the step input in chosen order
// - writes are self-timed from the rising edge
// - a lane is written when its strobe and write gate are low
// - global write low writes both lanes regardless of others
// - both strobes with write gate low write both lanes
// - processor strobe starts a cycle; ignored when primary select high
// - controller strobe with primary select high deselects
// - second select active high, third active low, both sampled
// - data pins driven when output enable low in a read cycle, else released
// - read data flows from the array with no output register
// - linear counts up modulo four; interleave xors the count
`timescale 1ns/100ps
`include "sbfr_cfg.svh"
module sbfr_core #(
  parameter int ADDR_W = `SBFR_ADDR_W,
  parameter int LANE_W = `SBFR_LANE_W
) (
  // clock and reset
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  // address and burst control
  input  wire sbfr_pkg::sbfr_addr_t      sync_addr_in_i,
  input  wire logic                      proc_start_strobe_n_i,
  input  wire logic                      ctrl_start_strobe_n_i,
  input  wire logic                      burst_step_n_i,
  input  wire logic                      burst_order_sel_i,
  // chip selects
  input  wire logic                      primary_select_n_i,
  input  wire logic                      depth_select_hi_i,
  input  wire logic                      depth_select_lo_n_i,
  // write control
  input  wire logic                      lane_lo_write_n_i,
  input  wire logic                      lane_hi_write_n_i,
  input  wire logic                      lane_write_gate_n_i,
  input  wire logic                      all_lanes_write_n_i,
  // output enable, not clocked
  input  wire logic                      out_enable_n_i,
  // data lanes, split into in, out and enable
  input  wire sbfr_pkg::sbfr_lane_t      data_lane_lo_i,
  input  wire sbfr_pkg::sbfr_lane_t      data_lane_hi_i,
  output sbfr_pkg::sbfr_lane_t           data_lane_lo_o,
  output sbfr_pkg::sbfr_lane_t           data_lane_hi_o,
  output logic                           data_lane_oe_o,
  // status
  output logic                           selected_o
);
  import sbfr_pkg::*;

  // ----------------------------------------------------------------
  // burst address function
  // ----------------------------------------------------------------
  // burst sequence math
  function automatic logic [1:0] burst_next(input logic [1:0] start,
                                            input logic [1:0] cnt,
                                            input sbfr_order_e ord);
    logic [1:0] res;
    res = (ord == SBFR_ORD_LINEAR) ? 2'(start + cnt) : (start ^ cnt);
    return res;
  endfunction

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [1:0]        cnt_r;
  logic [1:0]        cnt_nxt;
  sbfr_cyc_e         cyc_r;
  sbfr_cyc_e         cyc_nxt;
  logic              wr_lo_r;
  logic              wr_hi_r;
  logic [LANE_W-1:0] wd_lo_r;
  logic [LANE_W-1:0] wd_hi_r;

  // strap decode; only its steady level matters
  // order taken live
  sbfr_order_e order;
  assign order = burst_order_sel_i ? SBFR_ORD_INTERLEAVE : SBFR_ORD_LINEAR;

  // select decode
  // select polarity
  wire sel_ok    = !primary_select_n_i && depth_select_hi_i
                   && !depth_select_lo_n_i;
  wire proc_go   = !proc_start_strobe_n_i && !primary_select_n_i;
  wire ctrl_go   = !ctrl_start_strobe_n_i && proc_start_strobe_n_i
                   || !ctrl_start_strobe_n_i && primary_select_n_i;
  wire start_any = proc_go || ctrl_go;
  wire desel     = start_any && !sel_ok;
  wire step      = !start_any && !burst_step_n_i;

  // write decode; processor-strobe cycles always begin as reads
  // global write
  wire gw        = !all_lanes_write_n_i;
  wire lane_wr   = !lane_write_gate_n_i;
  wire wr_lo     = gw || lane_wr && !lane_lo_write_n_i;
  wire wr_hi     = gw || lane_wr && !lane_hi_write_n_i;
  wire any_wr    = (wr_lo || wr_hi) && !proc_go;
  wire active    = cyc_r != SBFR_CYC_IDLE;

  // next address and counter
  // external address load
  assign addr_nxt = (start_any && sel_ok) ? sync_addr_in_i : addr_r;
  assign cnt_nxt  = (start_any && sel_ok) ? `SBFR_CNT_RST :
                    (step && active) ? 2'(cnt_r + 2'h1) : cnt_r;

  // cycle kind
  always_comb begin
    cyc_nxt = cyc_r;
    case (cyc_r)
      SBFR_CYC_IDLE: begin
        if (start_any && sel_ok) begin
          cyc_nxt = any_wr ? SBFR_CYC_WRITE : SBFR_CYC_READ;
        end
      end
      SBFR_CYC_READ, SBFR_CYC_WRITE: begin
        if (desel) begin
          cyc_nxt = SBFR_CYC_IDLE;
        end else if (start_any) begin
          cyc_nxt = any_wr ? SBFR_CYC_WRITE : SBFR_CYC_READ;
        end else begin
          cyc_nxt = any_wr ? SBFR_CYC_WRITE : SBFR_CYC_READ;
        end
      end
      default: cyc_nxt = SBFR_CYC_IDLE;
    endcase
    if (desel) begin
      cyc_nxt = SBFR_CYC_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      addr_r <= '0;
      cnt_r  <= `SBFR_CNT_RST;
      cyc_r  <= SBFR_CYC_IDLE;
    end else begin
      addr_r <= addr_nxt;
      cnt_r  <= cnt_nxt;
      cyc_r  <= cyc_nxt;
    end
  end

  // write strobes and data registered; the array commits one edge later
  // self-timed write
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_lo_r <= 1'b0;
      wr_hi_r <= 1'b0;
      wd_lo_r <= '0;
      wd_hi_r <= '0;
    end else begin
      wr_lo_r <= wr_lo && !proc_go && !desel && (active || start_any);
      wr_hi_r <= wr_hi && !proc_go && !desel && (active || start_any);
      wd_lo_r <= data_lane_lo_i;
      wd_hi_r <= data_lane_hi_i;
    end
  end

  // ----------------------------------------------------------------
  // array and outputs
  // ----------------------------------------------------------------
  wire [ADDR_W-1:0] eff_addr = {addr_r[ADDR_W-1:2],
                                burst_next(addr_r[1:0], cnt_r, order)};
  logic [LANE_W-1:0] rd_lo;
  logic [LANE_W-1:0] rd_hi;

  sbfr_array #(
    .ADDR_W (ADDR_W),
    .LANE_W (LANE_W),
    .DEPTH  (1 << ADDR_W)
  ) u_array (
    .clk_sys_i  (clk_sys_i),
    .addr_i     (eff_addr),
    .wr_lo_i    (wr_lo_r),
    .wr_hi_i    (wr_hi_r),
    .wdata_lo_i (wd_lo_r),
    .wdata_hi_i (wd_hi_r),
    .rdata_lo_o (rd_lo),
    .rdata_hi_o (rd_hi)
  );

  assign data_lane_lo_o = rd_lo;
  assign data_lane_hi_o = rd_hi;
  // async output enable; drives during read cycles only
  assign data_lane_oe_o = !out_enable_n_i && cyc_r == SBFR_CYC_READ;
  assign selected_o     = active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_step_taken;
    !start_any && !burst_step_n_i && active;
  endsequence

  counter_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_step_taken |=> cnt_r == 2'($past(cnt_r) + 2'h1))
    else $error("burst counter did not advance");
  upper_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !start_any |=> $stable(addr_r)
    && $stable(eff_addr[ADDR_W-1:2]))
    else $error("upper address moved in burst");
  ext_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_any && sel_ok |=> addr_r == $past(sync_addr_in_i)
    && cnt_r == 2'h0)
    else $error("external address not loaded");
  ctrl_desel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !ctrl_start_strobe_n_i && primary_select_n_i
    |=> cyc_r == SBFR_CYC_IDLE)
    else $error("controller strobe failed to deselect");
  proc_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !proc_start_strobe_n_i && primary_select_n_i
    && ctrl_start_strobe_n_i
    |=> $stable(addr_r) && $stable(active))
    else $error("blocked processor strobe acted");
  global_wr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    gw && active && !start_any |=> wr_lo_r && wr_hi_r)
    else $error("global write missed a lane");
  lane_wr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !gw && active && !start_any |=> wr_lo_r == $past(lane_wr
    && !lane_lo_write_n_i))
    else $error("lane write mismatch");
  both_wr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lane_wr && !lane_lo_write_n_i && !lane_hi_write_n_i && active
    && !start_any |=> wr_lo_r && wr_hi_r)
    else $error("both-lane write missed");
  oe_drive_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    out_enable_n_i |-> !data_lane_oe_o)
    else $error("pins driven with enable high");
  flow_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    data_lane_oe_o |-> {data_lane_hi_o, data_lane_lo_o}
    == {u_array.mem_hi[eff_addr], u_array.mem_lo[eff_addr]})
    else $error("read data not flow-through");
  select_pol_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_any && (!depth_select_hi_i || depth_select_lo_n_i)
    |=> cyc_r == SBFR_CYC_IDLE)
    else $error("depth select polarity wrong");
endmodule

//--- core/sbfr_pkg.sv
// types shared by the burst sram core
// assumes the cfg header is compiled alongside
`include "sbfr_cfg.svh"
package sbfr_pkg;
  // burst sequencing order, taken from a strap level
  typedef enum logic {
    SBFR_ORD_LINEAR,
    SBFR_ORD_INTERLEAVE
  } sbfr_order_e;

  // cycle kind held between edges
  typedef enum logic [1:0] {
    SBFR_CYC_IDLE,
    SBFR_CYC_READ,
    SBFR_CYC_WRITE
  } sbfr_cyc_e;

  typedef logic [`SBFR_ADDR_W-1:0] sbfr_addr_t;
  typedef logic [`SBFR_LANE_W-1:0] sbfr_lane_t;
endpackage

//--- dv/sbfr_core_tb_top.sv
// self-checking bench for the burst sram core
// assumes the host model drives every core input except rst_i on falling edges
`timescale 1ns/100ps
module sbfr_core_tb_top;
  import sbfr_pkg::*;
  localparam logic [5:0] IDLE = 6'h3A;  // no strobe, selects active
  localparam logic [5:0] CST  = 6'h2A;  // controller start
  localparam logic [5:0] PST  = 6'h1A;  // processor start
  localparam logic [5:0] STP  = 6'h32;  // burst step
  localparam sbfr_addr_t BASE = 16'h5A3C;
  logic        clk_sys_i = 1'b0;
  logic        rst_i;
  int          bad_count = 0;
  int          cmp_count = 0;
  sbfr_addr_t  addr;
  logic [5:0]  st;
  logic [3:0]  wr_n;
  logic        oe_n, order, oe_o, sel_o;
  sbfr_lane_t  bus_lo, bus_hi, rd_lo, rd_hi;
  wire  [17:0] rd = {rd_hi, rd_lo};
  sbfr_host_model host (.clk_sys_i(clk_sys_i), .rd_lo_i(rd_lo),
    .rd_hi_i(rd_hi), .core_oe_i(oe_o), .addr_o(addr), .st_o(st),
    .order_o(order), .wr_n_o(wr_n), .oe_n_o(oe_n), .bus_lo_o(bus_lo),
    .bus_hi_o(bus_hi));
  sbfr_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sync_addr_in_i(addr), .proc_start_strobe_n_i(st[5]),
    .ctrl_start_strobe_n_i(st[4]), .burst_step_n_i(st[3]),
    .burst_order_sel_i(order), .primary_select_n_i(st[2]),
    .depth_select_hi_i(st[1]), .depth_select_lo_n_i(st[0]),
    .lane_lo_write_n_i(wr_n[0]), .lane_hi_write_n_i(wr_n[1]),
    .lane_write_gate_n_i(wr_n[2]), .all_lanes_write_n_i(wr_n[3]),
    .out_enable_n_i(oe_n), .data_lane_lo_i(bus_lo),
    .data_lane_hi_i(bus_hi), .data_lane_lo_o(rd_lo),
    .data_lane_hi_o(rd_hi), .data_lane_oe_o(oe_o), .selected_o(sel_o));
  // free-running clock
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic ord);
    rst_i = 1'b1;
    host.strap(ord);
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
  endtask
  // write commits one edge after the start cycle
  task automatic wr_word(input sbfr_addr_t a, input logic [3:0] w,
                         input logic [17:0] d);
    host.cyc(a, CST, w, 1'b1, d);
    host.cyc(a, IDLE, 4'hF, 1'b1, d);
  endtask
  task automatic rd_at(input sbfr_addr_t a);
    host.cyc(a, CST, 4'hF, 1'b1, 18'h00000);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // global write wins over gate and strobe levels
  task automatic t_write;
    logic [17:0] d;
    for (int k = 0; k < 2; k++) begin
      d = k ? 18'h1B2C5 : 18'h24D3A;
      wr_word(16'h0123, k ? 4'h5 : 4'h7, d);
      chk({17'h0, oe_o}, 18'h00000);
      rd_at(16'h0123);
      chk(rd, d);
      host.cyc(16'h0000, IDLE, 4'hF, 1'b0, 18'h00000);
      chk({rd[17:1], oe_o}, {d[17:1], 1'b1});
    end
    $display("write test done");
  endtask
  // lane strobes need the gate; both lanes with gate write the word
  task automatic t_bytes;
    logic [3:0]  code [4] = '{4'hA, 4'h9, 4'h8, 4'hC};
    logic [17:0] exp [4] = '{18'h3FE00, 18'h001FF, 18'h00000, 18'h3FFFF};
    for (int i = 0; i < 4; i++) begin
      wr_word(16'hFFFF, 4'h7, 18'h3FFFF);
      wr_word(16'hFFFF, code[i], 18'h00000);
      rd_at(16'hFFFF);
      chk(rd, exp[i]);
    end
    $display("byte test done");
  endtask
  // primary select blocks the processor strobe; others deselect
  task automatic t_select;
    logic [5:0] ds [3] = '{6'h2E, 6'h18, 6'h1B};
    for (int i = 0; i < 3; i++) begin
      rd_at(16'h0123);
      host.cyc(16'h0123, 6'h1E, 4'hF, 1'b0, 18'h00000);
      chk({17'h0, sel_o}, 18'h00001);
      host.cyc(16'h0123, ds[i], 4'hF, 1'b0, 18'h00000);
      chk({16'h0, sel_o, oe_o}, 18'h00000);
    end
    $display("select test done");
  endtask
  // every start offset, three steps, neighbour word guards the carry
  task automatic t_burst(input logic ord, input logic [5:0] how);
    logic [1:0] n;
    do_reset(ord);
    for (int i = 0; i < 5; i++) begin
      wr_word(BASE + 16'(i), 4'h7, {2'h2, BASE + 16'(i)});
    end
    for (int s = 0; s < 4; s++) begin
      host.cyc(BASE + 16'(s), how, 4'hF, 1'b0, 18'h00000);
      for (int k = 0; k < 4; k++) begin
        if (k > 0) begin
          host.cyc(16'h0000, STP, 4'hF, 1'b0, 18'h00000);
        end
        n = ord ? (s[1:0] ^ k[1:0]) : (s[1:0] + k[1:0]);
        chk(rd, {2'h2, BASE[15:2], n});
      end
    end
    $display("burst test done");
  endtask
  // write burst after a processor start, global and gated writes mixed,
  // read back word by word at the addresses the order should give
  task automatic t_wburst;
    logic [17:0] d [4];
    for (int k = 0; k < 4; k++) begin
      d[k] = {9'(16 + k), 9'(32 + k)};
    end
    host.cyc(16'h0C42, PST, 4'hF, 1'b1, 18'h00000);
    for (int k = 0; k < 4; k++) begin
      host.cyc(16'h0000, k ? STP : IDLE, k[0] ? 4'h8 : 4'h7, 1'b1, d[k]);
    end
    host.cyc(16'h0000, IDLE, 4'hF, 1'b1, 18'h00000);
    for (int k = 0; k < 4; k++) begin
      rd_at(16'h0C40 + 16'(2'h2 ^ k[1:0]));
      chk(rd, d[k]);
    end
    $display("burst write test done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    do_reset(1'b0);
    t_write;
    t_bytes;
    t_select;
    t_burst(1'b0, PST);
    t_burst(1'b1, CST);
    t_wburst;
    tally_and_finish;
  end
  // a run past this bound means something hung
  initial begin
    #800000;
    bad_count++;
    tally_and_finish;
  end
endmodule

//--- dv/sbfr_host_model.sv
// bus master model facing the burst sram core, one cycle per call
// assumes callers sit at a falling clock edge when they call cyc
`timescale 1ns/100ps
module sbfr_host_model (
  // clock and core read side
  input  wire logic                 clk_sys_i,
  input  wire sbfr_pkg::sbfr_lane_t rd_lo_i,
  input  wire sbfr_pkg::sbfr_lane_t rd_hi_i,
  input  wire logic                 core_oe_i,
  // address, strobes {proc,ctrl,step,sel,dhi,dlo} and strap
  output sbfr_pkg::sbfr_addr_t      addr_o,
  output logic [5:0]                st_o,
  output logic                      order_o,
  // writes {all,gate,hi,lo} and output enable
  output logic [3:0]                wr_n_o,
  output logic                      oe_n_o,
  // resolved data lanes
  output sbfr_pkg::sbfr_lane_t      bus_lo_o,
  output sbfr_pkg::sbfr_lane_t      bus_hi_o
);
  import sbfr_pkg::*;
  logic        drv;
  logic [17:0] wd;
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // released lanes show the inverse of the last host data, not a hold
  assign bus_lo_o = core_oe_i ? rd_lo_i : (drv ? wd[8:0] : ~wd[8:0]);
  assign bus_hi_o = core_oe_i ? rd_hi_i : (drv ? wd[17:9] : ~wd[17:9]);
  // quiet bus at time zero
  initial begin
    addr_o = 16'h0000;
    st_o = 6'h3A;
    order_o = 1'b0;
    wr_n_o = 4'hF;
    oe_n_o = 1'b1;
    drv = 1'b0;
    wd = 18'h00000;
  end
  // strap set only while the core sits in reset
  task automatic strap(input logic o);
    order_o = o;
  endtask
  task automatic cyc(input sbfr_addr_t a, input logic [5:0] st,
                     input logic [3:0] wr, input logic oe,
                     input logic [17:0] d);
    addr_o = a;  // whole bus, lowest bits on the burst inputs
    st_o = st;
    wr_n_o = wr;
    drv = (wr != 4'hF);
    oe_n_o = drv | oe;  // enable kept off around our own writes
    wd = d;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
endmodule
